// >>> design/adc_conversion_control.sv
// Purpose: Control, status and result logic of a 10-bit converter.
// Assumes: One clock; core result and trigger flags on the same clock.
// Notes:   Overview of operation below; assertions sit beside the logic.
//
// Overview of operation
// [R1] Result is input times 1024 over reference; 0x000 ground, 0x3FF top.
// [R2] Reference change during conversion applies only after that conversion completes.
// [R3] Reference codes: 00 external pin, 01 supply, 10 reserved, 11 internal.
// [R4] Alignment bit one left-aligns; view changes at once, even mid-conversion.
// [R5] Bit 4 of input select always reads zero.
// [R6] Channels 0-7 pins, 1110 bandgap, 1111 ground, 1000-1101 reserved.
// [R7] Channel change during conversion applies only after that conversion completes.
// [R8] Enable powers converter; clearing it aborts a running conversion.
// [R9] Writing start one starts each single conversion, or first free-run one.
// [R10] First conversion after enabling takes 25 converter clocks, later ones 13.
// [R11] Start bit reads one while converting; writing zero does nothing.
// [R12] With auto-trigger on, each rising trigger edge while idle starts a conversion.
// [R13] Completion flag sets when conversion finishes and result is updated; code sets it on every completion, even when the lock blocks the update.
// [R14] Flag clears on interrupt acknowledge or when software writes one.
// [R15] Interrupt requested while flag, enable and global enable all set.
// [R16] Prescaler divides by 2,2,4,8,16,32,64,128 for codes 0 to 7.
// [R17] Right: bits 9:8 high, 7:0 low; left: 9:2 high, 1:0 low top.
// [R18] After a low byte read, results stay frozen until high byte read.
// [R19] Software reads low byte first, unless left-aligned 8-bit use.
// [R20] Software avoids read-modify-write on control A to keep pending flags.
// [R21] Trigger select used only with auto-trigger; code 000 never triggers.
// [R22] Trigger codes: free, comparator, ext int 0, T0 A, T0 ovf, T1 B, T1 ovf, T1 capture.
// [R23] Unused result byte bits read zero in both alignments.
// [R24] Free running restarts a conversion at each completion while enabled.
`timescale 1ns/100ps

module adc_conversion_control (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire adc_ctrl_pkg::reg_req_t     bus_req,
    output logic [7:0]                      rd_data,
    input  wire logic [7:0]                 trig_src,
    input  wire logic                       irq_ack,
    input  wire logic                       global_irq_en,
    input  wire logic [9:0]                 core_result,
    output adc_ctrl_pkg::analog_ctrl_t      analog,
    output logic                            cmp_mux_en,
    output logic                            irq_req
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0]   ref_q;
    logic         align_q;
    logic [3:0]   chan_q;
    logic         en_q;
    logic         auto_q;
    logic         flag_q;
    logic         ie_q;
    logic [2:0]   div_q;
    logic         cmp_q;
    logic [2:0]   tsrc_q;
    logic [9:0]   result_q;
    logic         lock_q;
    conv_state_t  state_q;
    logic         init_q;
    logic [4:0]   cnt_q;
    logic [4:0]   len_q;
    logic [6:0]   pre_q;
    logic         trig_prev_q;
    logic [7:0]   rdata_q;
    logic         irq_q;
    analog_ctrl_t analog_q;
    analog_ctrl_t analog_d;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    wire       wr_in_sel  = bus_req.wr && bus_req.addr == ADDR_INPUT_SELECT;
    wire       wr_ctl_a   = bus_req.wr && bus_req.addr == ADDR_CONTROL_A;
    wire       wr_ctl_b   = bus_req.wr && bus_req.addr == ADDR_CONTROL_B;
    wire       rd_in_sel  = bus_req.rd && bus_req.addr == ADDR_INPUT_SELECT;
    wire       rd_res_lo  = bus_req.rd && bus_req.addr == ADDR_RESULT_LOW;
    wire       rd_res_hi  = bus_req.rd && bus_req.addr == ADDR_RESULT_HIGH;
    wire [7:0] wd         = bus_req.wdata;

    wire       busy       = state_q == ST_CONVERT;

    // Next values of the software fields
    wire [1:0] ref_d      = wr_in_sel ? wd[REF_MSB:REF_LSB] : ref_q;
    wire [3:0] chan_d     = wr_in_sel ? wd[CHAN_MSB:0] : chan_q;
    wire       en_d       = wr_ctl_a ? wd[EN_BIT] : en_q;

    ////////////////////////////////////////////////////////////////////////
    // Converter clock prescaler

    // [R16] Division factor select
    wire [7:0] div_full   = 8'h01 << div_q;
    wire [6:0] div_m1     = (div_q <= DIV_FLOOR_CODE) ? 7'h01 : 7'(div_full - 8'h01);
    wire       tick       = en_q && pre_q == div_m1;
    wire [6:0] pre_d      = (!en_q || tick) ? 7'h00 : 7'(pre_q + 7'h01);

    ////////////////////////////////////////////////////////////////////////
    // Trigger and start

    // [R22] Source index equals trigger code
    wire       trig_sel   = trig_src[tsrc_q];
    // [R12] Rising edge trigger
    // [R21] Free-run code masked
    wire       trig_edge  = auto_q && tsrc_q != TRIG_FREE && trig_sel && !trig_prev_q;

    // [R9] Software start
    // [R11] Zero writes ignored
    wire       sw_start   = wr_ctl_a && wd[START_BIT];
    wire       done       = busy && tick && cnt_q == 5'(len_q - 5'h01);
    // [R24] Free-running restart
    wire       free_next  = done && auto_q && tsrc_q == TRIG_FREE && en_d;
    wire       start      = (!busy && en_d && (sw_start || trig_edge)) || free_next;

    // [R8] Enable clear aborts
    wire       idle_next  = !en_d || (done && !start);
    conv_state_t state_d;
    assign state_d = idle_next ? ST_IDLE : (start ? ST_CONVERT : state_q);

    // [R10] First or normal length
    wire [4:0] len_d      = start ? ((init_q || !en_q) ? FIRST_CYCLES : NORMAL_CYCLES) : len_q;
    wire [4:0] cnt_d      = start ? 5'h00 : ((busy && tick) ? 5'(cnt_q + 5'h01) : cnt_q);
    wire       init_d     = !en_d ? 1'b1 : (start ? 1'b0 : init_q);

    ////////////////////////////////////////////////////////////////////////
    // Result, lock and flag

    // [R18] Lock between byte reads
    wire       upd        = done && !lock_q;
    wire       lock_d     = rd_res_hi ? 1'b0 : (rd_res_lo ? 1'b1 : lock_q);
    // [R1] Core code captured as is
    wire [9:0] result_d   = upd ? core_result : result_q;

    // [R13] Set on completion
    // [R14] Acknowledge or write-one clear
    wire       flag_clr   = irq_ack || (wr_ctl_a && wd[FLAG_BIT]);
    wire       flag_d     = done ? 1'b1 : (flag_clr ? 1'b0 : flag_q);

    // [R15] Interrupt request gate
    wire       irq_d      = flag_q && ie_q && global_irq_en;

    ////////////////////////////////////////////////////////////////////////
    // Read view

    // [R17] Alignment placement
    // [R23] Unused bits zero
    // [R4] Alignment acts at once
    wire [7:0] res_hi     = align_q ? result_q[9:2] : {6'h00, result_q[9:8]};
    wire [7:0] res_lo     = align_q ? {result_q[1:0], 6'h00} : result_q[7:0];
    // [R5] Reserved bit zero
    wire [7:0] in_sel_rd  = {ref_q, align_q, 1'b0, chan_q};
    wire [7:0] ctl_a_rd   = {en_q, busy, auto_q, flag_q, ie_q, div_q};
    wire [7:0] ctl_b_rd   = {1'b0, cmp_q, 3'h0, tsrc_q};

    wire [7:0] rd_mux     = (bus_req.addr == ADDR_INPUT_SELECT) ? in_sel_rd :
                            (bus_req.addr == ADDR_CONTROL_A)    ? ctl_a_rd  :
                            (bus_req.addr == ADDR_RESULT_LOW)   ? res_lo    :
                            (bus_req.addr == ADDR_RESULT_HIGH)  ? res_hi    :
                            (bus_req.addr == ADDR_CONTROL_B)    ? ctl_b_rd  :
                            8'h00;
    wire [7:0] rdata_d    = bus_req.rd ? rd_mux : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Analog selection

    // [R2] Reference held while busy
    // [R7] Channel held while busy
    wire       apply      = !busy || done || !en_d;

    always_comb begin
        analog_d              = analog_q;
        analog_d.power        = en_d;
        analog_d.sampling     = state_d == ST_CONVERT;
        if (apply) begin
            analog_d.reference = ref_d;
            analog_d.channel   = chan_d;
        end
        // [R3] Reference decode
        analog_d.ref_external = analog_d.reference == REF_EXTERNAL;
        analog_d.ref_supply   = analog_d.reference == REF_SUPPLY;
        analog_d.ref_internal = analog_d.reference == REF_INTERNAL;
        // [R6] Channel decode
        analog_d.chan_pin     = analog_d.channel <= CH_LAST_PIN;
        analog_d.chan_bandgap = analog_d.channel == CH_BANDGAP;
        analog_d.chan_ground  = analog_d.channel == CH_GROUND;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_q   <= INPUT_SELECT_RST[REF_MSB:REF_LSB];
            align_q <= INPUT_SELECT_RST[ALIGN_BIT];
            chan_q  <= INPUT_SELECT_RST[CHAN_MSB:0];
        end else if (ce) begin
            ref_q   <= ref_d;
            chan_q  <= chan_d;
            if (wr_in_sel) begin
                align_q <= wd[ALIGN_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q   <= CONTROL_A_RST[EN_BIT];
            auto_q <= CONTROL_A_RST[AUTO_BIT];
            ie_q   <= CONTROL_A_RST[IE_BIT];
            div_q  <= CONTROL_A_RST[DIV_MSB:0];
            flag_q <= CONTROL_A_RST[FLAG_BIT];
        end else if (ce) begin
            en_q   <= en_d;
            flag_q <= flag_d;
            if (wr_ctl_a) begin
                auto_q <= wd[AUTO_BIT];
                ie_q   <= wd[IE_BIT];
                div_q  <= wd[DIV_MSB:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_q  <= CONTROL_B_RST[CMP_BIT];
            tsrc_q <= CONTROL_B_RST[TSRC_MSB:0];
        end else if (ce && wr_ctl_b) begin
            cmp_q  <= wd[CMP_BIT];
            tsrc_q <= wd[TSRC_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            init_q      <= 1'b1;
            cnt_q       <= 5'h00;
            len_q       <= NORMAL_CYCLES;
            pre_q       <= 7'h00;
            trig_prev_q <= 1'b0;
        end else if (ce) begin
            state_q     <= state_d;
            init_q      <= init_d;
            cnt_q       <= cnt_d;
            len_q       <= len_d;
            pre_q       <= pre_d;
            trig_prev_q <= trig_sel;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_q <= RESULT_RST;
            lock_q   <= 1'b0;
            rdata_q  <= 8'h00;
            irq_q    <= 1'b0;
            analog_q <= '0;
        end else if (ce) begin
            result_q <= result_d;
            lock_q   <= lock_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
            analog_q <= analog_d;
        end
    end

    assign rd_data    = rdata_q;
    assign analog     = analog_q;
    assign cmp_mux_en = cmp_q;
    assign irq_req    = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // [R11] Start reads busy
    property p_start_reads_busy;
        @(posedge clk) disable iff (rst)
        ce && bus_req.rd && bus_req.addr == ADDR_CONTROL_A
        |=> rd_data[START_BIT] == $past(busy);
    endproperty
    a_start_reads_busy: assert property (p_start_reads_busy) // [R11]
        else $error("start bit does not mirror busy");

    // [R5] Reserved bit zero
    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        ce && rd_in_sel |=> rd_data[RES_BIT] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [R5]
        else $error("reserved select bit read as one");

    // [R13] Flag on completion
    property p_flag_set;
        @(posedge clk) disable iff (rst)
        ce && done |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) // [R13]
        else $error("flag not set after completion");

    // [R14] Write-one clears flag
    property p_flag_clear;
        @(posedge clk) disable iff (rst)
        ce && !done && wr_ctl_a && wd[FLAG_BIT] |=> !flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // [R14]
        else $error("flag survived a write of one");

    // [R15] Interrupt gating
    property p_irq_gate;
        @(posedge clk) disable iff (rst)
        ce |=> irq_req == ($past(flag_q) && $past(ie_q) && $past(global_irq_en));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [R15]
        else $error("interrupt request mismatch");

    // [R8] Disable aborts
    property p_abort;
        @(posedge clk) disable iff (rst)
        ce && wr_ctl_a && !wd[EN_BIT] |=> !busy && !analog.sampling;
    endproperty
    a_abort: assert property (p_abort) // [R8]
        else $error("conversion survived disable");

    // [R10] Conversion length
    property p_length;
        @(posedge clk) disable iff (rst)
        ce && start |=> cnt_q == 5'h00 &&
            len_q == (($past(init_q) || !$past(en_q)) ? FIRST_CYCLES : NORMAL_CYCLES);
    endproperty
    a_length: assert property (p_length) // [R10]
        else $error("wrong conversion length");

    // [R18] Locked result
    property p_lock_hold;
        @(posedge clk) disable iff (rst)
        ce && done && lock_q |=> $stable(result_q);
    endproperty
    a_lock_hold: assert property (p_lock_hold) // [R18]
        else $error("locked result was updated");

    // [R2] Reference deferred
    property p_ref_hold;
        @(posedge clk) disable iff (rst)
        ce && busy && !done && en_d |=> $stable(analog.reference);
    endproperty
    a_ref_hold: assert property (p_ref_hold) // [R2]
        else $error("reference changed mid-conversion");

    // [R7] Channel deferred
    property p_chan_hold;
        @(posedge clk) disable iff (rst)
        ce && busy && !done && en_d |=> $stable(analog.channel);
    endproperty
    a_chan_hold: assert property (p_chan_hold) // [R7]
        else $error("channel changed mid-conversion");

    // [R21] Free-run code silent
    property p_free_no_trig;
        @(posedge clk) disable iff (rst)
        ce && !busy && auto_q && tsrc_q == TRIG_FREE && !sw_start |=> !busy;
    endproperty
    a_free_no_trig: assert property (p_free_no_trig) // [R21]
        else $error("free-run code produced a trigger");

    // [R24] Free-run restart
    property p_free_restart;
        @(posedge clk) disable iff (rst)
        ce && done && auto_q && tsrc_q == TRIG_FREE && en_d
        |=> busy && cnt_q == 5'h00 && len_q == NORMAL_CYCLES;
    endproperty
    a_free_restart: assert property (p_free_restart) // [R24]
        else $error("free running did not restart");

endmodule : adc_conversion_control

// >>> design/adc_ctrl_pkg.sv
// Purpose: Shared constants and carrier types of the converter control block.
// Assumes: Byte-wide registers behind a plain strobe port.
// Notes:   Offsets, positions, resets and conversion lengths live here only.
package adc_ctrl_pkg;

    // Register offsets
    localparam logic [2:0] ADDR_INPUT_SELECT = 3'h0;
    localparam logic [2:0] ADDR_CONTROL_A    = 3'h1;
    localparam logic [2:0] ADDR_RESULT_LOW   = 3'h2;
    localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h3;
    localparam logic [2:0] ADDR_CONTROL_B    = 3'h4;

    // Input select fields
    localparam int REF_MSB   = 7;
    localparam int REF_LSB   = 6;
    localparam int ALIGN_BIT = 5;
    localparam int RES_BIT   = 4;
    localparam int CHAN_MSB  = 3;

    // Control A fields
    localparam int EN_BIT    = 7;
    localparam int START_BIT = 6;
    localparam int AUTO_BIT  = 5;
    localparam int FLAG_BIT  = 4;
    localparam int IE_BIT    = 3;
    localparam int DIV_MSB   = 2;

    // Control B fields
    localparam int CMP_BIT   = 6;
    localparam int TSRC_MSB  = 2;

    // Reset values
    localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] CONTROL_A_RST    = 8'h00;
    localparam logic [7:0] CONTROL_B_RST    = 8'h00;
    localparam logic [9:0] RESULT_RST       = 10'h000;

    // Conversion lengths in converter clocks (25 and 13)
    localparam logic [4:0] FIRST_CYCLES  = 5'h19;
    localparam logic [4:0] NORMAL_CYCLES = 5'h0D;

    // Codes
    localparam logic [1:0] REF_EXTERNAL   = 2'h0;
    localparam logic [1:0] REF_SUPPLY     = 2'h1;
    localparam logic [1:0] REF_INTERNAL   = 2'h3;
    localparam logic [3:0] CH_LAST_PIN    = 4'h7;
    localparam logic [3:0] CH_BANDGAP     = 4'hE;
    localparam logic [3:0] CH_GROUND      = 4'hF;
    localparam logic [2:0] TRIG_FREE      = 3'h0;
    localparam logic [2:0] DIV_FLOOR_CODE = 3'h1;

    typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       power;
        logic       sampling;
        logic [1:0] reference;
        logic [3:0] channel;
        logic       ref_external;
        logic       ref_supply;
        logic       ref_internal;
        logic       chan_pin;
        logic       chan_bandgap;
        logic       chan_ground;
    } analog_ctrl_t;

endpackage : adc_ctrl_pkg

// >>> tb/adc_core_model.sv
// Purpose: Behavioural analog sample-and-convert core facing the control block.
// Assumes: The code is taken on the cycle that ends a conversion.
// Notes:   The code depends on the applied reference and channel only.
`timescale 1ns/100ps

module adc_core_model (
    input  wire adc_ctrl_pkg::analog_ctrl_t analog,
    output logic [9:0]                      core_result
);
    import adc_ctrl_pkg::*;

    logic [9:0] code;

    assign code = {analog.reference, analog.channel, 4'hA};
    // Core idle: the result lines show the inverse, not the last code
    assign core_result = analog.sampling ? code : ~code;
endmodule : adc_core_model

// >>> tb/tb_adc_conversion_control.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: Bus master drives right after the rising edge; data read one cycle later.
// Notes:   Conversion lengths are judged against the prescaler phase window.
`timescale 1ns/100ps

module tb_adc_conversion_control;
    import adc_ctrl_pkg::*;

    logic         clk;
    logic         rst;
    logic         ce;
    reg_req_t     req;
    logic [7:0]   rd_data;
    logic [7:0]   trig_src;
    logic         irq_ack;
    logic         global_irq_en;
    logic [9:0]   core_result;
    analog_ctrl_t analog;
    logic         cmp_mux_en;
    logic         irq_req;
    int           bad_count;
    int           n_checks;
    int           cyc;

    adc_conversion_control DUT (.clk(clk), .rst(rst), .ce(ce), .bus_req(req), .rd_data(rd_data),
        .trig_src(trig_src), .irq_ack(irq_ack), .global_irq_en(global_irq_en),
        .core_result(core_result), .analog(analog), .cmp_mux_en(cmp_mux_en), .irq_req(irq_req));
    adc_core_model core (.analog(analog), .core_result(core_result));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input string nm, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(nm, e, rd_data);
    endtask : rdchk

    // Waits for the end of a conversion started at cycle t0
    task automatic wait_idle(input int t0, input int lo, input int hi);
        while (analog.sampling === 1'b1 && cyc - t0 < 5000) begin
            @(posedge clk);
            #1;
        end
        chk("conv_cycles_in_window", 1, (cyc - t0 >= lo) && (cyc - t0 <= hi));
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 0; a < 6; a++) rdchk("reset_value", a[2:0], 8'h00);
        wr(3'h5, 8'hFF);
        rdchk("unmapped", 3'h5, 8'h00);
        // Clock enable low must swallow a write
        @(posedge clk);
        ce <= 1'b0;
        wr(ADDR_INPUT_SELECT, 8'hFF);
        @(posedge clk);
        ce <= 1'b1;
        rdchk("frozen_write", ADDR_INPUT_SELECT, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_select();
        logic [7:0] dat [4] = '{8'hFF, 8'h4E, 8'h07, 8'h88};
        logic [5:0] dec [4] = '{6'b001001, 6'b010010, 6'b100100, 6'b000000};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_INPUT_SELECT, dat[i]);
            @(posedge clk);
            #1;
            rdchk("select_readback", ADDR_INPUT_SELECT, dat[i] & 8'hEF);
            chk("applied_select", {dat[i][7:6], dat[i][3:0]}, {analog.reference, analog.channel});
            chk("select_decode", dec[i], {analog.ref_external, analog.ref_supply, analog.ref_internal,
                analog.chan_pin, analog.chan_bandgap, analog.chan_ground});
        end
        $display("test select done");
    endtask : t_select

    task automatic t_convert();
        int t0;
        wr(ADDR_INPUT_SELECT, 8'h03);
        global_irq_en <= 1'b1;
        wr(ADDR_CONTROL_A, 8'hC8);
        t0 = cyc;
        chk("power_on", 1, analog.power);
        wr(ADDR_INPUT_SELECT, 8'h45);
        chk("held_select", 6'h03, {analog.reference, analog.channel});
        rdchk("busy_bit", ADDR_CONTROL_A, 8'hC8);
        wait_idle(t0, 49, 52);
        chk("applied_after", 6'h15, {analog.reference, analog.channel});
        rdchk("flag_set", ADDR_CONTROL_A, 8'h98);
        chk("irq_request", 1, irq_req);
        rdchk("right_low", ADDR_RESULT_LOW, 8'h3A);
        rdchk("right_high", ADDR_RESULT_HIGH, 8'h00);
        wr(ADDR_INPUT_SELECT, 8'h65);
        rdchk("left_low", ADDR_RESULT_LOW, 8'h80);
        wr(ADDR_CONTROL_A, 8'hD8);
        t0 = cyc;
        wait_idle(t0, 25, 28);
        rdchk("locked_high", ADDR_RESULT_HIGH, 8'h0E);
        rdchk("locked_low", ADDR_RESULT_LOW, 8'h80);
        rdchk("locked_high2", ADDR_RESULT_HIGH, 8'h0E);
        rdchk("flag_locked", ADDR_CONTROL_A, 8'h98);
        global_irq_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("irq_masked", 0, irq_req);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        rdchk("flag_ack", ADDR_CONTROL_A, 8'h88);
        wr(ADDR_INPUT_SELECT, 8'h45);
        wr(ADDR_CONTROL_A, 8'hC8);
        t0 = cyc;
        wait_idle(t0, 25, 28);
        rdchk("new_low", ADDR_RESULT_LOW, 8'h5A);
        rdchk("new_high", ADDR_RESULT_HIGH, 8'h01);
        wr(ADDR_CONTROL_A, 8'hD8);
        chk("flag_write_one", 1, analog.sampling);
        rdchk("flag_write_one_clear", ADDR_CONTROL_A, 8'hC8);
        wait_idle(t0, 0, 5000);
        $display("test convert done");
    endtask : t_convert

    task automatic t_prescale();
        int t0;
        int dv;
        for (int c = 0; c < 8; c++) begin
            dv = (c < 2) ? 2 : (1 << c);
            wr(ADDR_CONTROL_A, 8'hC0 | c[7:0]);
            t0 = cyc;
            wait_idle(t0, 13 * dv - dv + 1, 13 * dv + 2);
        end
        $display("test prescale done");
    endtask : t_prescale

    task automatic t_trigger();
        wr(ADDR_CONTROL_B, 8'h40);
        chk("cmp_mux", 1, cmp_mux_en);
        rdchk("control_b", ADDR_CONTROL_B, 8'h40);
        wr(ADDR_CONTROL_A, 8'hA0);
        for (int c = 1; c < 8; c++) begin
            wr(ADDR_CONTROL_B, c[7:0]);
            trig_src <= 8'h01 << c;
            repeat (3) @(posedge clk);
            #1;
            chk("trigger_start", 1, analog.sampling);
            wait_idle(cyc, 0, 5000);
            trig_src <= 8'h00;
            @(posedge clk);
        end
        wr(ADDR_CONTROL_B, 8'h00);
        trig_src <= 8'hFF;
        repeat (4) @(posedge clk);
        #1;
        chk("free_code_no_trigger", 0, analog.sampling);
        trig_src <= 8'h00;
        $display("test trigger done");
    endtask : t_trigger

    task automatic t_freerun();
        // Start free running and clear the flag left by earlier tests
        wr(ADDR_CONTROL_A, 8'hF0);
        repeat (30) @(posedge clk);
        #1;
        chk("free_restart", 1, analog.sampling);
        rdchk("poll", ADDR_CONTROL_A, 8'hF0);
        wr(ADDR_CONTROL_A, 8'h10);
        chk("abort", 2'b00, {analog.power, analog.sampling});
        repeat (40) @(posedge clk);
        rdchk("no_flag_after_abort", ADDR_CONTROL_A, 8'h00);
        $display("test freerun done");
    endtask : t_freerun

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        #1000000;
        bad_count++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req = '0;
        trig_src = 8'h00;
        irq_ack = 1'b0;
        global_irq_en = 1'b0;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_select();
        t_convert();
        t_prescale();
        t_trigger();
        t_freerun();
        complete_run();
    end
endmodule : tb_adc_conversion_control
